/* core/hst_defs.svh */
// Constants for the pixel histogram binning block
`ifndef HST_DEFS_SVH
`define HST_DEFS_SVH

// Data widths
`define HST_PIX_W 16
`define HST_CRD_W 16
`define HST_CNT_W 20
`define HST_CNT_MAX 20'hFFFFF
`define HST_BIN_IDX_W 12

// Register byte addresses
`define HST_ADDR_W 16
`define HST_CTRL_ADDR 16'h0000
`define HST_STAT_ADDR 16'h0004
`define HST_HREG_BASE 16'h0010
`define HST_VREG_BASE 16'h0020
`define HST_BIN_SEL 2'h1

// Control register fields
`define HST_CTRL_EN 0
`define HST_CTRL_SRC 1
`define HST_CTRL_ACLR 2
`define HST_CTRL_NREG_LSB 3
`define HST_CTRL_NBIN_LSB 5
`define HST_CTRL_SHIFT_LSB 8
`define HST_CTRL_MASK 32'h0000077F
`define HST_CTRL_RST 32'h00000000

// Coordinate register halves
`define HST_START_LSB 0
`define HST_END_LSB 16
`define HST_COORD_RST 32'h00000000

// Bin sizing
`define HST_MIN_BINS 9'h020
`define HST_NUM_REG 4

`endif

/* core/hst_pkg.sv */
// Types shared by the histogram binning modules
`include "hst_defs.svh"
package hst_pkg;

   typedef struct packed
   {
      logic [`HST_PIX_W-1:0] value;
      logic [1:0] colour;
      logic [`HST_CRD_W-1:0] x;
      logic [`HST_CRD_W-1:0] y;
   } hst_pix_t;

   typedef enum logic {HST_IDLE, HST_UPD} hst_state_t;

endpackage : hst_pkg

/* core/hst_pix_if.sv */
// Pixel stream carrier between the input buffer and the binning engine
`timescale 1ns/1ps
interface hst_pix_if;
   import hst_pkg::*;
   logic valid;
   logic ready;
   hst_pix_t data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : hst_pix_if

/* core/hst_buf2.sv */
// Two-entry pixel buffer with valid/ready on both sides
`timescale 1ns/1ps
module hst_buf2
   import hst_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Streams
   hst_pix_if.snk i_in,
   hst_pix_if.src o_out
);

   hst_pix_t ent_ff [2];
   hst_pix_t nxt_ent [2];
   logic wptr_ff, nxt_wptr;
   logic rptr_ff, nxt_rptr;
   logic [1:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign i_in.ready = (cnt_ff != 2'h2);
   assign o_out.valid = (cnt_ff != 2'h0);
   assign o_out.data = ent_ff[rptr_ff];
   assign push = i_in.valid && i_in.ready;
   assign pop = o_out.valid && o_out.ready;

   always_comb
   begin
      nxt_ent = ent_ff;
      nxt_wptr = wptr_ff;
      nxt_rptr = rptr_ff;
      nxt_cnt = cnt_ff;
      if (push)
      begin
         nxt_ent[wptr_ff] = i_in.data;
         nxt_wptr = !wptr_ff;
      end
      if (pop)
      begin
         nxt_rptr = !rptr_ff;
      end
      if (push && !pop)
      begin
         nxt_cnt = cnt_ff + 2'h1;
      end
      else if (pop && !push)
      begin
         nxt_cnt = cnt_ff - 2'h1;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         ent_ff[0] <= '0;
         ent_ff[1] <= '0;
         wptr_ff <= 1'b0;
         rptr_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end
      else
      begin
         ent_ff <= nxt_ent;
         wptr_ff <= nxt_wptr;
         rptr_ff <= nxt_rptr;
         cnt_ff <= nxt_cnt;
      end
   end

endmodule : hst_buf2

/* core/hst_binning.sv */
// Pixel histogram binning engine with register port and bin RAM
//
// Contract
// R1 - Raw pixels of three or four colours are counted by value, colours kept apart.
// R2 - A bin holds only a pixel count, never pixel values.
// R3 - Input is selectable between the live capture stream and the memory stream.
// R4 - One to four collection regions are supported.
// R5 - Each region has its own horizontal and vertical start and end.
// R6 - Overlapping pixels count only in the lowest-numbered region containing them.
// R7 - Each region keeps four colour components in separate bin sets.
// R8 - Bins per colour per region are 32, 64, 128 or 256.
// R9 - Software limits bins by region count: 256 for one, 128 for two, 64 for three or four.
// R10 - With auto-clear on, a bin location reads back and is zeroed by the host read.
// R11 - Bin counters are 20 bits and saturate instead of wrapping.
// R12 - Pixel values are shifted right by 0 to 7 before bin selection.
// R13 - The top bin collects every value at or above its lower bound.
// R14 - Region boundaries are inclusive.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`include "hst_defs.svh"
module hst_binning
   import hst_pkg::*;
#(
   parameter int PIX_W = `HST_PIX_W
)
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Register port
   input wire logic [`HST_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Live capture stream
   input wire logic i_live_valid,
   output logic o_live_ready,
   input wire logic [PIX_W-1:0] i_live_value,
   input wire logic [1:0] i_live_colour,
   input wire logic [`HST_CRD_W-1:0] i_live_x,
   input wire logic [`HST_CRD_W-1:0] i_live_y,
   // Memory read-back stream
   input wire logic i_mem_valid,
   output logic o_mem_ready,
   input wire logic [PIX_W-1:0] i_mem_value,
   input wire logic [1:0] i_mem_colour,
   input wire logic [`HST_CRD_W-1:0] i_mem_x,
   input wire logic [`HST_CRD_W-1:0] i_mem_y
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   localparam int NREG = `HST_NUM_REG;
   localparam int BIN_DEPTH = 1 << `HST_BIN_IDX_W;

   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [31:0] hreg_ff [NREG];
   logic [31:0] nxt_hreg [NREG];
   logic [31:0] vreg_ff [NREG];
   logic [31:0] nxt_vreg [NREG];
   logic [31:0] rdata_ff, nxt_rdata;
   hst_state_t state_ff, nxt_state;
   logic [`HST_BIN_IDX_W-1:0] bidx_ff, nxt_bidx;

   // Bin RAM: four regions x four colours x 256 bins, counts only
   logic [`HST_CNT_W-1:0] bin_mem [BIN_DEPTH]; // R2

   logic en, sel_mem, aclr;
   logic [1:0] nreg_m1, nbin_sel;
   logic [2:0] shift;

   logic is_ctrl, is_stat, is_h, is_v, is_bin;
   logic [1:0] reg_sel;
   logic [`HST_BIN_IDX_W-1:0] host_idx;

   logic [NREG-1:0] hit;
   logic [1:0] win_reg;
   logic [PIX_W-1:0] shifted;
   logic [7:0] top_bin;
   logic [7:0] bin;
   logic host_clr;
   logic mem_we;
   logic [`HST_BIN_IDX_W-1:0] mem_wa;
   logic [`HST_CNT_W-1:0] mem_wd;
   logic [`HST_CNT_W-1:0] cur_cnt;

   hst_pix_if buf_in ();
   hst_pix_if buf_out ();

   ////////////////////////////////////////////////////////////////////////////////
   // Control fields

   assign en = ctrl_ff[`HST_CTRL_EN];
   assign sel_mem = ctrl_ff[`HST_CTRL_SRC];
   assign aclr = ctrl_ff[`HST_CTRL_ACLR];
   assign nreg_m1 = ctrl_ff[`HST_CTRL_NREG_LSB +: 2]; // R4
   assign nbin_sel = ctrl_ff[`HST_CTRL_NBIN_LSB +: 2]; // R8
   assign shift = ctrl_ff[`HST_CTRL_SHIFT_LSB +: 3];
   assign o_rdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Input selection and buffering

   // Unselected source sees ready low, so it simply holds its word
   always_comb
   begin
      if (sel_mem) // R3
      begin
         buf_in.valid = i_mem_valid;
         buf_in.data = '{value: i_mem_value, colour: i_mem_colour, x: i_mem_x, y: i_mem_y};
      end
      else
      begin
         buf_in.valid = i_live_valid;
         buf_in.data = '{value: i_live_value, colour: i_live_colour, x: i_live_x, y: i_live_y};
      end
   end

   assign o_live_ready = !sel_mem && buf_in.ready; // R3
   assign o_mem_ready = sel_mem && buf_in.ready; // R3

   hst_buf2 u_buf (
      .i_ref_clk (i_ref_clk),
      .i_reset (i_reset),
      .i_in (buf_in),
      .o_out (buf_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Region match and bin selection

   genvar r;
   generate
      for (r = 0; r < NREG; r++)
      begin : g_reg
         assign hit[r] = (2'(r) <= nreg_m1) // R4
            && (buf_out.data.x >= hreg_ff[r][`HST_START_LSB +: `HST_CRD_W]) // R5 R14
            && (buf_out.data.x <= hreg_ff[r][`HST_END_LSB +: `HST_CRD_W]) // R5 R14
            && (buf_out.data.y >= vreg_ff[r][`HST_START_LSB +: `HST_CRD_W]) // R5 R14
            && (buf_out.data.y <= vreg_ff[r][`HST_END_LSB +: `HST_CRD_W]); // R5 R14
      end
   endgenerate

   // Scan from the lowest priority so region zero lands last
   always_comb
   begin
      win_reg = 2'h0;
      for (int i = NREG - 1; i >= 0; i--)
      begin
         if (hit[i])
         begin
            win_reg = 2'(i); // R6
         end
      end
   end

   // Colours with only three in use simply leave code 3 idle
   always_comb
   begin
      shifted = buf_out.data.value >> shift; // R12
      top_bin = 8'((`HST_MIN_BINS << nbin_sel) - 9'h001); // R8
      if (shifted >= PIX_W'(top_bin)) // R13
      begin
         bin = top_bin;
      end
      else
      begin
         bin = shifted[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Host decode

   assign is_ctrl = (i_addr == `HST_CTRL_ADDR);
   assign is_stat = (i_addr == `HST_STAT_ADDR);
   assign is_h = ((i_addr >> 4) == (`HST_HREG_BASE >> 4));
   assign is_v = ((i_addr >> 4) == (`HST_VREG_BASE >> 4));
   assign is_bin = (i_addr[`HST_ADDR_W-1:14] == `HST_BIN_SEL);
   assign reg_sel = i_addr[3:2];
   assign host_idx = i_addr[13:2];
   assign host_clr = i_rd && is_bin && aclr; // R10

   ////////////////////////////////////////////////////////////////////////////////
   // Register file

   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      nxt_hreg = hreg_ff;
      nxt_vreg = vreg_ff;
      nxt_rdata = 32'h00000000;
      if (i_wr)
      begin
         if (is_ctrl)
         begin
            nxt_ctrl = i_wdata & `HST_CTRL_MASK;
         end
         if (is_h)
         begin
            nxt_hreg[reg_sel] = i_wdata; // R5
         end
         if (is_v)
         begin
            nxt_vreg[reg_sel] = i_wdata; // R5
         end
      end
      if (i_rd)
      begin
         if (is_ctrl)
         begin
            nxt_rdata = ctrl_ff;
         end
         else if (is_stat)
         begin
            nxt_rdata = {30'h0, buf_out.valid, (state_ff == HST_UPD)};
         end
         else if (is_h)
         begin
            nxt_rdata = hreg_ff[reg_sel];
         end
         else if (is_v)
         begin
            nxt_rdata = vreg_ff[reg_sel];
         end
         else if (is_bin)
         begin
            nxt_rdata = {12'h000, bin_mem[host_idx]}; // R10
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         ctrl_ff <= `HST_CTRL_RST;
         rdata_ff <= 32'h00000000;
         for (int i = 0; i < NREG; i++)
         begin
            hreg_ff[i] <= `HST_COORD_RST;
            vreg_ff[i] <= `HST_COORD_RST;
         end
      end
      else
      begin
         ctrl_ff <= nxt_ctrl;
         rdata_ff <= nxt_rdata;
         hreg_ff <= nxt_hreg;
         vreg_ff <= nxt_vreg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Binning engine: one pixel per two cycles, read then write back

   assign buf_out.ready = (state_ff == HST_IDLE);
   assign cur_cnt = bin_mem[bidx_ff];

   always_comb
   begin
      nxt_state = state_ff;
      nxt_bidx = bidx_ff;
      unique case (state_ff)
         HST_IDLE:
         begin
            // Disabled or outside all regions: word is drained uncounted
            if (buf_out.valid && en && (|hit))
            begin
               nxt_bidx = {win_reg, buf_out.data.colour, bin}; // R1 R7
               nxt_state = HST_UPD;
            end
         end
         HST_UPD:
         begin
            // A clearing host read owns the write port; retry next cycle
            if (!host_clr)
            begin
               nxt_state = HST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         state_ff <= HST_IDLE;
         bidx_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         bidx_ff <= nxt_bidx;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bin RAM write port

   always_comb
   begin
      mem_we = 1'b0;
      mem_wa = bidx_ff;
      mem_wd = cur_cnt;
      if (host_clr)
      begin
         mem_we = 1'b1;
         mem_wa = host_idx;
         mem_wd = '0; // R10
      end
      else if (state_ff == HST_UPD)
      begin
         mem_we = 1'b1;
         if (cur_cnt != `HST_CNT_MAX) // R11
         begin
            mem_wd = cur_cnt + 20'h00001;
         end
      end
   end

   // Not reset: software clears bins by auto-clear reads before use
   always_ff @(posedge i_ref_clk)
   begin
      if (mem_we)
      begin
         bin_mem[mem_wa] <= mem_wd;
      end
   end

endmodule : hst_binning

/* dv/hst_binning_sva.sv */
// Port checks for the histogram binning block
`timescale 1ns/1ps
`include "hst_defs.svh"
module hst_binning_sva
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Register port
   input wire logic [`HST_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   // Streams
   input wire logic i_live_valid,
   input wire logic o_live_ready,
   input wire logic i_mem_valid,
   input wire logic o_mem_ready
);
   logic [31:0] ctl_ff;
   logic [2:0] qt_ff;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   // Quiet count: no increment may still be pending once it saturates
   always_ff @(posedge i_ref_clk or posedge i_reset)
      if (i_reset)
      begin
         ctl_ff <= 32'h0;
         qt_ff <= 3'h0;
      end
      else
      begin
         if (i_wr && i_addr == `HST_CTRL_ADDR)
            ctl_ff <= i_wdata & `HST_CTRL_MASK;
         if (i_live_valid && o_live_ready || i_mem_valid && o_mem_ready)
            qt_ff <= 3'h0;
         else if (qt_ff != 3'h7)
            qt_ff <= qt_ff + 3'h1;
      end
   sequence s_clr;
      i_rd && i_addr[15:14] == `HST_BIN_SEL && ctl_ff[`HST_CTRL_ACLR] && qt_ff == 3'h7;
   endsequence
   rd_idle_zero_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data not zero when idle");
   ctrl_read_a: assert property (i_rd && i_addr == `HST_CTRL_ADDR |=> o_rdata == ctl_ff)
      else $error("control read back wrong");
   stat_upper_a: assert property (i_rd && i_addr == `HST_STAT_ADDR |=> o_rdata[31:2] == 30'h0)
      else $error("status spare bits set");
   gap_read_a: assert property (i_rd && i_addr == 16'h0008 |=> o_rdata == 32'h0)
      else $error("unmapped read not zero");
   bin_width_a: assert property (i_rd && i_addr[15:14] == `HST_BIN_SEL |=> o_rdata[31:20] == 12'h0)
      else $error("bin wider than 20 bits");
   live_sel_a: assert property (o_live_ready |-> !ctl_ff[`HST_CTRL_SRC])
      else $error("live ready while memory selected");
   mem_sel_a: assert property (o_mem_ready |-> ctl_ff[`HST_CTRL_SRC])
      else $error("memory ready while live selected");
   clear_read_a: assert property (s_clr ##1 i_rd && $stable(i_addr) |=> o_rdata == 32'h0)
      else $error("bin not cleared by read");
endmodule : hst_binning_sva
bind hst_binning hst_binning_sva u_sva (.i_ref_clk, .i_reset, .i_addr, .i_wdata, .i_wr,
   .i_rd, .o_rdata, .i_live_valid, .o_live_ready, .i_mem_valid, .o_mem_ready);

/* dv/hst_src_model.sv */
// Pixel source standing in for capture or memory reader
`timescale 1ns/1ps
module hst_src_model
(
   // Clock
   input wire logic i_ref_clk,
   // Stream
   input wire logic i_ready,
   output logic o_valid,
   output logic [15:0] o_value,
   output logic [1:0] o_colour,
   output logic [15:0] o_x,
   output logic [15:0] o_y
);
   initial
   begin
      o_valid = 1'b0;
      {o_value, o_colour, o_x, o_y} = 50'h0;
   end
   // Word held until ready is seen at an edge
   task send(input logic [49:0] w, output bit ok);
      bit r;
      ok = 1'b0;
      if (!o_valid)
         o_valid <= 1'b1;
      {o_value, o_colour, o_x, o_y} <= w;
      repeat (64)
      begin
         @(negedge i_ref_clk) r = i_ready;
         @(posedge i_ref_clk);
         if (r)
         begin
            ok = 1'b1;
            break;
         end
      end
   endtask : send
   // Stale word inverted so it never looks current
   task stop();
      o_valid <= 1'b0;
      {o_value, o_colour, o_x, o_y} <= ~{o_value, o_colour, o_x, o_y};
   endtask : stop
endmodule : hst_src_model

/* dv/test_pixel_histogram_binning.sv */
// Self-checking bench for the histogram binning block
`timescale 1ns/1ps
`include "hst_defs.svh"
module test_pixel_histogram_binning;
   logic i_ref_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [15:0] i_addr = 16'h0;
   logic [31:0] i_wdata = 32'h0;
   logic [31:0] o_rdata, d, lfsr = 32'hC3EA;
   logic i_live_valid, o_live_ready, i_mem_valid, o_mem_ready;
   logic [15:0] i_live_value, i_live_x, i_live_y, i_mem_value, i_mem_x, i_mem_y;
   logic [1:0] i_live_colour, i_mem_colour;
   int miscompares = 0, n_tests = 0, nb, nr, sh, en, src, ac;
   int q [4096], b [8], e [8];
   initial forever #5 i_ref_clk = ~i_ref_clk;
   hst_binning DUT (.i_ref_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_live_valid, .o_live_ready, .i_live_value, .i_live_colour, .i_live_x, .i_live_y,
      .i_mem_valid, .o_mem_ready, .i_mem_value, .i_mem_colour, .i_mem_x, .i_mem_y);
   hst_src_model u_live (.i_ref_clk, .i_ready(o_live_ready), .o_valid(i_live_valid),
      .o_value(i_live_value), .o_colour(i_live_colour), .o_x(i_live_x), .o_y(i_live_y));
   hst_src_model u_mem (.i_ref_clk, .i_ready(o_mem_ready), .o_valid(i_mem_valid),
      .o_value(i_mem_value), .o_colour(i_mem_colour), .o_x(i_mem_x), .o_y(i_mem_y));
   //////////
   function automatic int rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd
   task cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask : cmp
   // Strobe left high so reads can run back to back
   task acc(input logic w, input logic [15:0] a, input logic [31:0] wd);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= a;
      i_wdata <= wd;
      @(posedge i_ref_clk);
      #1 d = o_rdata;
   endtask : acc
   task rb(input bit chk, input bit clr);
      for (int i = 0; i < 4096; i++)
         repeat (2)
         begin
            acc(1'b0, 16'h4000 + 16'(i * 4), 32'h0);
            if (chk)
               cmp("bin", q[i], d);
            if (clr)
               q[i] = 0;
         end
      i_rd <= 1'b0;
   endtask : rb
   task pix();
      int v, c, x, y, k;
      logic [49:0] w;
      bit ok;
      v = rnd() & 32'h7FF;
      c = rnd() & 3;
      if (!src)
         c = c % 3;
      x = rnd() & 63;
      y = rnd() & 63;
      w = {v[15:0], c[1:0], x[15:0], y[15:0]};
      if (src)
         u_mem.send(w, ok);
      else
         u_live.send(w, ok);
      if (!ok)
      begin
         miscompares++;
         summarize();
      end
      for (k = 0; k <= nr; k++)
         if (x >= b[k] && x <= e[k] && y >= b[k + 4] && y <= e[k + 4])
         begin
            v = v >> sh;
            if (v > (32 << nb) - 1)
               v = (32 << nb) - 1;
            v = k * 1024 + c * 256 + v;
            if (en && q[v] < 32'hFFFFF)
               q[v]++;
            break;
         end
      if (rnd() & 8)
      begin
         u_live.stop();
         u_mem.stop();
         @(posedge i_ref_clk);
      end
   endtask : pix
   task summarize();
      $display("Checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   //////////
   initial
   begin
      repeat (3) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      @(posedge i_ref_clk);
      #1 acc(1'b0, `HST_CTRL_ADDR, 32'h0);
      cmp("ctrl", `HST_CTRL_RST, d);
      acc(1'b0, `HST_VREG_BASE, 32'h0);
      cmp("coord", `HST_COORD_RST, d);
      acc(1'b1, `HST_CTRL_ADDR, 32'h4);
      rb(1'b0, 1'b1);
      // Bin count kept within the region limit
      for (int p = 0; p < 5; p++)
      begin
         nb = p & 3;
         nr = (p == 4) ? 3 : 3 - p;
         sh = rnd() & 7;
         en = p < 4;
         src = p & 1;
         ac = p != 1;
         for (int k = 0; k < 8; k++)
         begin
            b[k] = rnd() & 31;
            e[k] = b[k] + (rnd() & 31);
            acc(1'b1, 16'h10 + 16'(k * 4), {16'(e[k]), 16'(b[k])});
         end
         acc(1'b1, `HST_CTRL_ADDR, (sh << 8) | (nb << 5) | (nr << 3) | (ac << 2) | (src << 1) | en);
         acc(1'b0, 16'h2C, 32'h0);
         cmp("coord", {16'(e[7]), 16'(b[7])}, d);
         i_rd <= 1'b0;
         @(posedge i_ref_clk);
         #1 cmp("ready", 32'h0, {31'h0, src ? o_live_ready : o_mem_ready});
         cmp("ready", 32'h1, {31'h0, src ? o_mem_ready : o_live_ready});
         repeat (150) pix();
         u_live.stop();
         u_mem.stop();
         repeat (10) @(posedge i_ref_clk);
         #1 acc(1'b0, `HST_STAT_ADDR, 32'h0);
         cmp("stat", 32'h0, d);
         acc(1'b0, 16'h0008, 32'h0);
         cmp("gap", 32'h0, d);
         rb(1'b1, ac);
         $display("Pass %0d done", p);
      end
      summarize();
   end
endmodule : test_pixel_histogram_binning
